// file: rtl/adc_seq_pkg.sv
// Constants, types and register map of the scan conversion sequencer
//
// How it works
// - Conversions run while start is high and stop while it is low.
// - Start falling lets the running conversion finish, then idle follows.
// - Start rising in scan mode begins at the current pointer, then loops.
// - After the last selected channel the scan wraps to the highest priority.
// - A single selected channel is converted repeatedly, pointer unchanged.
// - Writing any scan select register reloads the pointer to highest priority.
// - Fixed mode moves the pointer only on a scan select write and uses the fixed pair register.
// - Start dropped before 8 clocks ahead of ready converts one channel only.
// - With start low each pulse command converts one channel, at byte end.
// - A pulse conversion in scan mode advances to the next selected channel.
// - General output data updates on the eighth falling serial clock edge.
// - First result after start waits the settling delay per rate and idle depth.
// - Later results come at the plain conversion period.
// - Config register a picks scan or fixed converting mode.
// - Config register b picks standby or sleep idle; sleep waits longer.
// - Scan list holds 8 pairs, 16 single inputs and 5 internal readings.
// - At ready the flag falls, pointer moves in scan mode, next conversion or idle.
// - Only selected channels are converted, in list order.
// - Pair k drives input 2k positive and input 2k+1 negative.
// - Fixed mode takes any input as positive and any as negative.
// - Power-down is entered from idle only; it then stops all converting and sequencing.
// - Ready releases on first falling serial edge; unread results pulse it.
package adc_seq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CFG_A  = 8'h00;
  localparam logic [7:0] OFS_CFG_B  = 8'h04;
  localparam logic [7:0] OFS_DIFF   = 8'h08;
  localparam logic [7:0] OFS_SE_LO  = 8'h0C;
  localparam logic [7:0] OFS_SE_HI  = 8'h10;
  localparam logic [7:0] OFS_SYS    = 8'h14;
  localparam logic [7:0] OFS_FIXED  = 8'h18;
  localparam logic [7:0] OFS_GPIO   = 8'h1C;
  localparam logic [7:0] OFS_CMD    = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // ==========================================================
  // Field positions and reset values
  localparam int         CFGA_FIXED_BIT = 0;
  localparam int         CFGA_PD_BIT    = 1;
  localparam int         CFGB_SLEEP_BIT = 0;
  localparam int         CFGB_RATE_LSB  = 1;
  localparam int         CMD_PULSE_BIT  = 0;
  localparam logic [7:0] CFG_B_RST      = 8'h06;
  localparam logic [7:0] SEL_RST        = 8'h00;
  // ==========================================================
  // Timing in master clock cycles
  localparam logic [13:0] INIT_FIX_R11  = 14'd802;
  localparam logic [13:0] INIT_SCAN_R11 = 14'd708;
  localparam logic [13:0] INIT_FIX_R10  = 14'd1186;
  localparam logic [13:0] INIT_SCAN_R10 = 14'd1092;
  localparam logic [13:0] INIT_FIX_R01  = 14'd2722;
  localparam logic [13:0] INIT_SCAN_R01 = 14'd2628;
  localparam logic [13:0] SLEEP_EXTRA   = 14'd64;
  localparam logic [13:0] LATE_CLKS     = 14'd8;
  // ==========================================================
  // Channel space and priority order
  localparam int NCH = 29;
  localparam logic [4:0] PRIO_TAB [0:NCH-1] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13,
    5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_DOWN   = 2'b11
  } seq_state_e;
  typedef enum logic [1:0] {
    MUX_PAIR = 2'b00,
    MUX_COM  = 2'b01,
    MUX_SYS  = 2'b10
  } mux_kind_e;
  typedef struct packed {
    mux_kind_e  kind;
    logic [3:0] pos;
    logic [3:0] neg;
  } mux_sel_s;
endpackage

// file: rtl/adc_scan_sequencer.sv
// Scan conversion sequencer with Wishbone register slave
`timescale 1ns/10ps
module adc_scan_sequencer #(
  parameter int INIT_FIX_R00  = 8866,
  parameter int INIT_SCAN_R00 = 8772,
  parameter int CONV_R11      = 128,
  parameter int CONV_R10      = 256,
  parameter int CONV_R01      = 512,
  parameter int CONV_R00      = 1024
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Pins
  input  wire logic                  start_i,
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  output logic                       result_ready_n_o,
  output logic      [7:0]            gpio_o,
  // Converter control
  output adc_seq_pkg::mux_sel_s      mux_o,
  output logic      [4:0]            channel_o,
  output logic                       converting_o,
  output logic                       idle_sleep_o,
  output logic                       power_down_o
);
  // ==========================================================
  // Registers and state
  logic [7:0]              cfg_a;
  logic [7:0]              cfg_b;
  logic [7:0]              diff_sel;
  logic [7:0]              se_lo;
  logic [7:0]              se_hi;
  logic [4:0]              sys_sel;
  logic [7:0]              fixed_pair;
  logic [7:0]              gpio_stage;
  logic                    gpio_arm;
  logic                    pulse_arm;
  logic                    ack;
  logic [2:0]              sync1;
  logic [2:0]              sync2;
  logic [2:0]              sync3;
  logic [2:0]              bit_cnt;
  adc_seq_pkg::seq_state_e state;
  adc_seq_pkg::seq_state_e next_state;
  logic [13:0]             cnt;
  logic [4:0]              ptr;
  logic                    ptr_reload;
  logic                    go_on;
  logic                    ready_n;
  logic                    ready_bump;
  logic [4:0]              first_pos;
  logic [4:0]              next_pos;
  logic                    next_hit;
  logic [31:0]             rd_word;

  // ==========================================================
  // Bus decode
  wire       req      = wb_cyc_i & wb_stb_i & ~ack;
  wire       wr       = req & wb_we_i & wb_sel_i[0];
  wire       wr_cfga  = wr & (wb_adr_i == adc_seq_pkg::OFS_CFG_A);
  wire       wr_cfgb  = wr & (wb_adr_i == adc_seq_pkg::OFS_CFG_B);
  wire       wr_diff  = wr & (wb_adr_i == adc_seq_pkg::OFS_DIFF);
  wire       wr_selo  = wr & (wb_adr_i == adc_seq_pkg::OFS_SE_LO);
  wire       wr_sehi  = wr & (wb_adr_i == adc_seq_pkg::OFS_SE_HI);
  wire       wr_sys   = wr & (wb_adr_i == adc_seq_pkg::OFS_SYS);
  wire       wr_fixed = wr & (wb_adr_i == adc_seq_pkg::OFS_FIXED);
  wire       wr_gpio  = wr & (wb_adr_i == adc_seq_pkg::OFS_GPIO);
  wire       wr_cmd   = wr & (wb_adr_i == adc_seq_pkg::OFS_CMD)
                        & wb_dat_i[adc_seq_pkg::CMD_PULSE_BIT];
  wire       wr_list  = wr_diff | wr_selo | wr_sehi | wr_sys;
  // ==========================================================
  // Config fields
  wire       fixed_md = cfg_a[adc_seq_pkg::CFGA_FIXED_BIT];
  wire       pd_req   = cfg_a[adc_seq_pkg::CFGA_PD_BIT];
  wire       sleep_md = cfg_b[adc_seq_pkg::CFGB_SLEEP_BIT];
  wire [1:0] rate     = cfg_b[adc_seq_pkg::CFGB_RATE_LSB +: 2];
  wire [adc_seq_pkg::NCH-1:0] sel_vec = {sys_sel, se_hi, se_lo, diff_sel};
  // ==========================================================
  // Pin sampling and serial edge detection
  wire start_s  = sync2[2];
  wire sclk_fal = sync3[1] & ~sync2[1];
  wire cs_act   = ~sync2[0];
  wire sfall    = sclk_fal & cs_act;
  wire byte_end = sfall & (bit_cnt == 3'h7);
  wire pulse_go = byte_end & pulse_arm & ~start_s;
  // ==========================================================
  // Delay selection
  wire [13:0] init_fix  = (rate == 2'b11) ? adc_seq_pkg::INIT_FIX_R11
                        : (rate == 2'b10) ? adc_seq_pkg::INIT_FIX_R10
                        : (rate == 2'b01) ? adc_seq_pkg::INIT_FIX_R01
                        : 14'(INIT_FIX_R00);
  wire [13:0] init_scan = (rate == 2'b11) ? adc_seq_pkg::INIT_SCAN_R11
                        : (rate == 2'b10) ? adc_seq_pkg::INIT_SCAN_R10
                        : (rate == 2'b01) ? adc_seq_pkg::INIT_SCAN_R01
                        : 14'(INIT_SCAN_R00);
  wire [13:0] init_load = (fixed_md ? init_fix : init_scan)
                        + (sleep_md ? adc_seq_pkg::SLEEP_EXTRA : 14'h0000)
                        - 14'h0001;
  wire [13:0] conv_load = (rate == 2'b11) ? 14'(CONV_R11 - 1)
                        : (rate == 2'b10) ? 14'(CONV_R10 - 1)
                        : (rate == 2'b01) ? 14'(CONV_R01 - 1)
                        : 14'(CONV_R00 - 1);
  wire busy      = (state == adc_seq_pkg::ST_SETTLE) | (state == adc_seq_pkg::ST_CONV);
  wire done      = busy & (cnt == 14'h0000);
  wire wake      = start_s | pulse_go;
  // Scan mode advances; fixed mode and a lone channel stay put
  wire [4:0] adv_pos = next_hit ? next_pos : first_pos;
  wire [4:0] cur_ch  = adc_seq_pkg::PRIO_TAB[ptr];

  // ==========================================================
  // Priority search over the scan list
  always_comb begin
    first_pos = 5'h00;
    next_pos  = 5'h00;
    next_hit  = 1'b0;
    for (int i = adc_seq_pkg::NCH - 1; i >= 0; i--) begin
      if (sel_vec[adc_seq_pkg::PRIO_TAB[i]]) begin
        first_pos = 5'(i);
        if (5'(i) > ptr) begin
          next_pos = 5'(i);
          next_hit = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Sequencer state machine
  always_comb begin
    next_state = state;
    unique case (state)
      adc_seq_pkg::ST_IDLE: begin
        if (pd_req) begin
          next_state = adc_seq_pkg::ST_DOWN;
        end else if (wake) begin
          next_state = adc_seq_pkg::ST_SETTLE;
        end
      end
      adc_seq_pkg::ST_SETTLE, adc_seq_pkg::ST_CONV: begin
        if (done) begin
          next_state = go_on ? adc_seq_pkg::ST_CONV
                             : adc_seq_pkg::ST_IDLE;
        end
      end
      adc_seq_pkg::ST_DOWN: begin
        if (!pd_req) begin
          next_state = adc_seq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= adc_seq_pkg::ST_IDLE;
      cnt   <= 14'h0000;
      go_on <= 1'b0;
    end else begin
      state <= next_state;
      if (state == adc_seq_pkg::ST_IDLE) begin
        cnt   <= init_load;
        go_on <= start_s;
      end else if (done) begin
        cnt   <= conv_load;
        go_on <= start_s;
      end else if (busy) begin
        cnt <= cnt - 14'h0001;
        // Later start changes ride into the next conversion only
        if (cnt == adc_seq_pkg::LATE_CLKS) begin
          go_on <= start_s;
        end
      end
    end
  end

  // ==========================================================
  // Channel pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr        <= 5'h00;
      ptr_reload <= 1'b0;
    end else begin
      // Reload one cycle late so the search sees the new list
      ptr_reload <= wr_list;
      if (ptr_reload) begin
        ptr <= first_pos;
      end else if (done && !fixed_md) begin
        ptr <= adv_pos;
      end
    end
  end

  // ==========================================================
  // Converter input selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_o     <= '{kind: adc_seq_pkg::MUX_PAIR, pos: 4'h0, neg: 4'h1};
      channel_o <= 5'h00;
    end else if (fixed_md) begin
      mux_o     <= '{kind: adc_seq_pkg::MUX_PAIR,
                     pos:  fixed_pair[7:4],
                     neg:  fixed_pair[3:0]};
      channel_o <= 5'h00;
    end else begin
      channel_o <= cur_ch;
      if (cur_ch < 5'd8) begin
        mux_o <= '{kind: adc_seq_pkg::MUX_PAIR,
                   pos:  {cur_ch[2:0], 1'b0},
                   neg:  {cur_ch[2:0], 1'b1}};
      end else if (cur_ch < 5'd24) begin
        mux_o <= '{kind: adc_seq_pkg::MUX_COM,
                   pos:  4'(cur_ch - 5'd8),
                   neg:  4'h0};
      end else begin
        mux_o <= '{kind: adc_seq_pkg::MUX_SYS,
                   pos:  4'(cur_ch - 5'd24),
                   neg:  4'h0};
      end
    end
  end

  // ==========================================================
  // Ready flag: unread results give a one-cycle high bump
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_n    <= 1'b1;
      ready_bump <= 1'b0;
    end else begin
      ready_bump <= done & ~ready_n;
      if (done) begin
        ready_n <= ~ready_n;
      end else if (ready_bump) begin
        ready_n <= 1'b0;
      end else if (sfall && bit_cnt == 3'h0) begin
        ready_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial edge sampling and byte counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1   <= 3'h1;
      sync2   <= 3'h1;
      sync3   <= 3'h1;
      bit_cnt <= 3'h0;
    end else begin
      sync1 <= {start_i, sclk_i, cs_n_i};
      sync2 <= sync1;
      sync3 <= sync2;
      if (!cs_act) begin
        bit_cnt <= 3'h0;
      end else if (sfall) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // Software registers; arm bits let a new write win over byte end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_a      <= adc_seq_pkg::SEL_RST;
      cfg_b      <= adc_seq_pkg::CFG_B_RST;
      diff_sel   <= adc_seq_pkg::SEL_RST;
      se_lo      <= adc_seq_pkg::SEL_RST;
      se_hi      <= adc_seq_pkg::SEL_RST;
      sys_sel    <= 5'h00;
      fixed_pair <= adc_seq_pkg::SEL_RST;
      gpio_stage <= adc_seq_pkg::SEL_RST;
      gpio_o     <= adc_seq_pkg::SEL_RST;
      gpio_arm   <= 1'b0;
      pulse_arm  <= 1'b0;
    end else begin
      if (wr_cfga) begin
        cfg_a <= wb_dat_i[7:0];
      end
      if (wr_cfgb) begin
        cfg_b <= wb_dat_i[7:0];
      end
      if (wr_diff) begin
        diff_sel <= wb_dat_i[7:0];
      end
      if (wr_selo) begin
        se_lo <= wb_dat_i[7:0];
      end
      if (wr_sehi) begin
        se_hi <= wb_dat_i[7:0];
      end
      if (wr_sys) begin
        sys_sel <= wb_dat_i[4:0];
      end
      if (wr_fixed) begin
        fixed_pair <= wb_dat_i[7:0];
      end
      if (wr_gpio) begin
        gpio_stage <= wb_dat_i[7:0];
        gpio_arm   <= 1'b1;
      end else if (byte_end) begin
        gpio_arm <= 1'b0;
      end
      if (byte_end && gpio_arm) begin
        gpio_o <= gpio_stage;
      end
      if (wr_cmd) begin
        pulse_arm <= 1'b1;
      end else if (byte_end) begin
        pulse_arm <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux and bus answer; unmapped reads give zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      adc_seq_pkg::OFS_CFG_A:  rd_word[7:0] = cfg_a;
      adc_seq_pkg::OFS_CFG_B:  rd_word[7:0] = cfg_b;
      adc_seq_pkg::OFS_DIFF:   rd_word[7:0] = diff_sel;
      adc_seq_pkg::OFS_SE_LO:  rd_word[7:0] = se_lo;
      adc_seq_pkg::OFS_SE_HI:  rd_word[7:0] = se_hi;
      adc_seq_pkg::OFS_SYS:    rd_word[4:0] = sys_sel;
      adc_seq_pkg::OFS_FIXED:  rd_word[7:0] = fixed_pair;
      adc_seq_pkg::OFS_GPIO:   rd_word[7:0] = gpio_stage;
      adc_seq_pkg::OFS_CMD:    rd_word[1:0] = {gpio_arm, pulse_arm};
      adc_seq_pkg::OFS_STATUS: rd_word[9:0] = {ready_n, state, go_on, ptr, start_s};
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  assign wb_ack_o         = ack;
  assign result_ready_n_o = ready_n;
  assign converting_o     = busy;
  assign idle_sleep_o     = sleep_md & (state == adc_seq_pkg::ST_IDLE);
  assign power_down_o     = (state == adc_seq_pkg::ST_DOWN);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ready_bump_a: assert property (done && !ready_n |=> ready_n ##1 !ready_n)
    else $error("unread result did not bump ready");
  fixed_ptr_a: assert property (fixed_md && !ptr_reload |=> $stable(ptr))
    else $error("pointer moved in fixed mode");
  list_reload_a: assert property (wr_list |-> ##2 ptr == first_pos)
    else $error("pointer not reloaded after list write");
  stop_idle_a: assert property (done && !go_on |=> state == adc_seq_pkg::ST_IDLE)
    else $error("no idle after stop");
  pulse_conv_a: assert property (state == adc_seq_pkg::ST_IDLE && !pd_req && pulse_go
                                 |=> state == adc_seq_pkg::ST_SETTLE)
    else $error("pulse command ignored");
  gpio_update_a: assert property (byte_end && gpio_arm |=> gpio_o == $past(gpio_stage))
    else $error("output data not updated at byte end");
  power_down_a: assert property (state == adc_seq_pkg::ST_IDLE && pd_req
                                 |=> power_down_o && !converting_o)
    else $error("power down not entered");
  init_load_a: assert property (state == adc_seq_pkg::ST_IDLE && wake && !pd_req
                                |=> cnt == $past(init_load))
    else $error("wrong settling delay");
  run_on_a: assert property (done && go_on
                             |=> state == adc_seq_pkg::ST_CONV && cnt == $past(conv_load))
    else $error("continuous conversion wrong period");
  scan_step_a: assert property (done && !fixed_md && !ptr_reload
                                |=> ptr == $past(adv_pos))
    else $error("pointer did not advance");
endmodule

// file: testbench/adc_host_model.sv
// Host side model driving the start pin and the serial port
`timescale 1ns/10ps
module adc_host_model (
  // Clock
  input  wire logic clk_i,
  // Pins towards the sequencer
  output logic      start_i,
  output logic      sclk_i,
  output logic      cs_n_i
);
  // ==========================================================
  // Idle levels: serial clock stands still low outside frames
  initial begin
    start_i = 1'b0;
    sclk_i  = 1'b0;
    cs_n_i  = 1'b1;
  end
  // ==========================================================
  // Start level is held as long as the host wants conversions
  task automatic set_start(input logic v);
    @(posedge clk_i);
    start_i <= v;
  endtask
  // One byte: eight falling edges with select low, 80 ns per bit
  task automatic send_byte();
    @(posedge clk_i);
    cs_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    repeat (8) begin
      sclk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    cs_n_i <= 1'b1;
  endtask
endmodule

// file: testbench/adc_scan_sequencer_bench.sv
// Self-checking bench of the scan conversion sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module adc_scan_sequencer_bench;
  localparam int CONV = 128;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack;
  logic [7:0] adr, gpio;
  logic [3:0] sel, wsel;
  logic [31:0] wdat, rdat, q;
  logic start, sclk, cs_n, rdy_n, conv, slp, pd;
  logic [4:0] ch;
  adc_seq_pkg::mux_sel_s mux;
  int miscompares = 0, cmp_count = 0, cyc_cnt = 0, n, n_scan;
  typedef struct { logic [7:0] a; logic [31:0] w; logic [31:0] e; } row_s;
  row_s rows [0:6] = '{'{8'h04, 32'h5, 32'h5}, '{8'h08, 32'hA5, 32'hA5},
    '{8'h0C, 32'h3C, 32'h3C}, '{8'h10, 32'hC3, 32'hC3}, '{8'h14, 32'h1F, 32'h1F},
    '{8'h18, 32'h52, 32'h52}, '{8'h30, 32'hFF, 32'h0}};
  // ==========================================================
  // Clock, timeout and instances
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  adc_host_model host (.clk_i(clk_i), .start_i(start), .sclk_i(sclk), .cs_n_i(cs_n));
  adc_scan_sequencer #(.CONV_R11(CONV)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .start_i(start), .sclk_i(sclk),
    .cs_n_i(cs_n), .result_ready_n_o(rdy_n), .gpio_o(gpio), .mux_o(mux),
    .channel_o(ch), .converting_o(conv), .idle_sleep_o(slp), .power_down_o(pd));
  // ==========================================================
  // Bus cycle held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= wsel;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 50) miscompares++;
  endtask
  // Cycles until the next falling edge of the ready flag
  task automatic next_rdy(output int c);
    logic p;
    c = 0;
    p = rdy_n;
    do begin p = rdy_n; @(posedge clk_i); c++; end
    while (!(p === 1'b1 && rdy_n === 1'b0) && c < 12000);
    if (c >= 12000) miscompares++;
    // Registered channel outputs trail the moved pointer by a cycle
    repeat (2) begin
      @(posedge clk_i);
      c++;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    sel <= 4'h0;
    wdat <= 32'h0;
    wsel = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("rdy", 1'b1, rdy_n)
    `CHK("conv", 1'b0, conv)
    wb(8'h04, 1'b0, 0); `CHK("cfgb", 32'h6, q)
    foreach (rows[i]) begin
      wb(rows[i].a, 1'b1, rows[i].w);
      wb(rows[i].a, 1'b0, 0);
      `CHK("reg", rows[i].e, q)
    end
    // A write with byte lane 0 off must leave the register alone
    wsel = 4'hE;
    wb(8'h18, 1'b1, 32'h33);
    wsel = 4'hF;
    wb(8'h18, 1'b0, 0);
    `CHK("sel", 32'h52, q)
    wb(8'h04, 1'b1, 32'h6); wb(8'h00, 1'b1, 0); wb(8'h08, 1'b1, 32'h9);
    wb(8'h10, 1'b1, 0); wb(8'h14, 1'b1, 0); wb(8'h0C, 1'b1, 32'h1);
    repeat (4) @(posedge clk_i);
    host.set_start(1'b1);
    next_rdy(n_scan); `CHK("init", 1'b1, n_scan >= 708 && n_scan <= 716)
    `CHK("ch", 5'd3, ch)
    `CHK("pos", 4'h6, mux.pos)
    `CHK("neg", 4'h7, mux.neg)
    // First result was unread, so the second fall waits one bump cycle
    next_rdy(n); `CHK("period", CONV + 1, n)
    `CHK("ch", 5'd8, ch)
    next_rdy(n); `CHK("ch", 5'd0, ch)
    `CHK("period", CONV, n)
    host.set_start(1'b0);
    next_rdy(n); `CHK("ch", 5'd3, ch)
    repeat (20) @(posedge clk_i); `CHK("conv", 1'b0, conv)
    // Pulse step converts one channel and moves on by one
    wb(8'h20, 1'b1, 32'h1); host.send_byte();
    next_rdy(n); `CHK("ch", 5'd8, ch)
    repeat (20) @(posedge clk_i); `CHK("conv", 1'b0, conv)
    host.send_byte(); repeat (6) @(posedge clk_i); `CHK("rdy", 1'b1, rdy_n)
    // A single internal reading keeps the pointer still
    wb(8'h08, 1'b1, 0); wb(8'h0C, 1'b1, 0); wb(8'h14, 1'b1, 32'h1);
    repeat (4) @(posedge clk_i); `CHK("ch", 5'd24, ch)
    `CHK("kind", adc_seq_pkg::MUX_SYS, mux.kind)
    wb(8'h04, 1'b1, 32'h7); `CHK("slp", 1'b1, slp)
    host.set_start(1'b1);
    next_rdy(n); `CHK("sleep", 64, n - n_scan)
    next_rdy(n); `CHK("ch", 5'd24, ch)
    host.set_start(1'b0); next_rdy(n); repeat (20) @(posedge clk_i);
    // A read releases the flag so the next first result falls at once
    host.send_byte();
    repeat (6) @(posedge clk_i);
    `CHK("rdy", 1'b1, rdy_n)
    // Fixed mode with a short start pulse
    wb(8'h04, 1'b1, 32'h6); wb(8'h00, 1'b1, 32'h1); wb(8'h18, 1'b1, 32'h52);
    host.set_start(1'b1); repeat (5) @(posedge clk_i); host.set_start(1'b0);
    // Counting began six cycles after start rose here
    next_rdy(n); `CHK("fixed", 94, n - n_scan + 6)
    `CHK("pos", 4'h5, mux.pos)
    `CHK("neg", 4'h2, mux.neg)
    `CHK("ch", 5'd0, ch)
    repeat (CONV + 20) @(posedge clk_i); `CHK("conv", 1'b0, conv)
    wb(8'h1C, 1'b1, 32'hA5); host.send_byte(); repeat (6) @(posedge clk_i);
    `CHK("gpio", 8'hA5, gpio)
    wb(8'h00, 1'b1, 32'h2); repeat (3) @(posedge clk_i);
    `CHK("pd", 1'b1, pd)
    wrap_up();
  end
endmodule
